// ==== hdl/regulator_vbus_defs.svh ====
/*
 Offsets, field positions, reset values and synchroniser depth for the regulator control register.
 Assumes inclusion by bare name from design files.
*/
`ifndef REGULATOR_VBUS_DEFS_SVH
`define REGULATOR_VBUS_DEFS_SVH
`define REG_CTRL_ADDR 8'hc9
`define REG_CTRL_RESET 8'h00
`define BIT_REG_OFF 7
`define BIT_BUS_PRESENT 6
`define BIT_IRQ_POL 5
`define BIT_LOW_POWER 4
`define RESERVED_MASK 8'h0f
`define SYNC_STAGES 2
`endif

// ==== hdl/regulator_vbus_pkg.sv ====
/*
 Types shared by the regulator control block.
 Assumes the defines header is compiled alongside.
*/
package regulator_vbus_pkg;
    typedef logic [7:0] sfr_byte_t;
    typedef logic [7:0] sfr_addr_t;
endpackage : regulator_vbus_pkg

// ==== hdl/vbus_sync.sv ====
/*
 Two-stage synchroniser for the supply-line detect pin.
 Assumes an asynchronous input and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "regulator_vbus_defs.svh"
module vbus_sync #(
    parameter int STAGES = `SYNC_STAGES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic async_in,
    output logic sync_out
);
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;

    always_comb begin
        next_chain = {chain[STAGES-2:0], async_in};
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            chain <= '0;
        end else begin
            chain <= next_chain;
        end
    end

    assign sync_out = chain[STAGES-1];
endmodule : vbus_sync

// ==== hdl/regulator_vbus_control.sv ====
/*
 Regulator control and supply-line detect register with interrupt and reset request.
 Assumes a special-function-register port on mclk: one-cycle strobes, read data next cycle.
*/
`timescale 1ns/1ps
`include "regulator_vbus_defs.svh"
module regulator_vbus_control (
    input wire logic mclk,
    input wire logic resetn,
    input wire regulator_vbus_pkg::sfr_addr_t sfr_addr,
    input wire regulator_vbus_pkg::sfr_byte_t sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output regulator_vbus_pkg::sfr_byte_t sfr_rdata,
    input wire logic vbus_pin,
    input wire logic irq_enable,
    input wire logic reset_source_sel,
    output logic regulator_off,
    output logic regulator_low_power_select,
    output logic bus_power_irq,
    output logic bus_power_reset_req
);
    import regulator_vbus_pkg::*;

    logic bus_power_present;
    logic bus_power_irq_polarity;
    logic next_off;
    logic next_low_power;
    logic next_polarity;
    sfr_byte_t next_rdata;
    logic next_irq;
    logic next_reset_req;
    logic match;
    logic hit;

    vbus_sync #(.STAGES(`SYNC_STAGES)) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(vbus_pin),
        .sync_out(bus_power_present)
    );

    function automatic sfr_byte_t pack_reg(input logic off, input logic pres,
                                           input logic pol, input logic lp);
        sfr_byte_t v;
        v = `REG_CTRL_RESET;
        v[`BIT_REG_OFF] = off;
        v[`BIT_BUS_PRESENT] = pres;
        v[`BIT_IRQ_POL] = pol;
        v[`BIT_LOW_POWER] = lp;
        v = v & ~`RESERVED_MASK;
        return v;
    endfunction : pack_reg

    always_comb begin
        hit = (sfr_addr == `REG_CTRL_ADDR);
        match = (bus_power_present == bus_power_irq_polarity);
    end

    always_comb begin
        next_off = regulator_off;
        next_low_power = regulator_low_power_select;
        next_polarity = bus_power_irq_polarity;
        if (sfr_wr && hit) begin
            next_off = sfr_wdata[`BIT_REG_OFF];
            next_polarity = sfr_wdata[`BIT_IRQ_POL];
            next_low_power = sfr_wdata[`BIT_LOW_POWER];
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            regulator_off <= 1'b0;
            regulator_low_power_select <= 1'b0;
            bus_power_irq_polarity <= 1'b0;
        end else begin
            regulator_off <= next_off;
            regulator_low_power_select <= next_low_power;
            bus_power_irq_polarity <= next_polarity;
        end
    end

    // Read data stands one cycle and is zero otherwise.
    always_comb begin
        next_rdata = 8'h00;
        if (sfr_rd && hit) begin
            next_rdata = pack_reg(regulator_off, bus_power_present,
                                  bus_power_irq_polarity, regulator_low_power_select);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= next_rdata;
        end
    end

    always_comb begin
        next_irq = irq_enable && match;
        next_reset_req = reset_source_sel && match;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bus_power_irq <= 1'b0;
            bus_power_reset_req <= 1'b0;
        end else begin
            bus_power_irq <= next_irq;
            bus_power_reset_req <= next_reset_req;
        end
    end

    sequence s_write_hit;
        sfr_wr && hit;
    endsequence

    sequence s_read_hit;
        sfr_rd && hit;
    endsequence

    sequence s_write_off(v);
        sfr_wr && hit && sfr_wdata[`BIT_REG_OFF] == v;
    endsequence

    chk_irq_follows_match: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn) |-> bus_power_irq == $past(irq_enable && match))
        else $error("irq mismatch");

    chk_irq_disabled: assert property (@(posedge mclk) disable iff (!resetn)
        !irq_enable |=> !bus_power_irq)
        else $error("irq while disabled");

    // Irq drops one cycle after the match ends.
    chk_irq_level_drop: assert property (@(posedge mclk) disable iff (!resetn)
        !match |=> !bus_power_irq)
        else $error("irq latched");

    // Irq stands while the match lasts.
    chk_irq_level_hold: assert property (@(posedge mclk) disable iff (!resetn)
        (irq_enable && match) |=> bus_power_irq)
        else $error("irq not raised");

    // Polarity zero raises irq on low level.
    chk_irq_pol_low: assert property (@(posedge mclk) disable iff (!resetn)
        (irq_enable && !bus_power_irq_polarity && !bus_power_present) |=> bus_power_irq)
        else $error("irq missing on low level");

    // Polarity one raises irq on high level.
    chk_irq_pol_high: assert property (@(posedge mclk) disable iff (!resetn)
        (irq_enable && bus_power_irq_polarity && bus_power_present) |=> bus_power_irq)
        else $error("irq missing on high level");

    // Reset request follows source and match.
    chk_reset_req_match: assert property (@(posedge mclk) disable iff (!resetn)
        (reset_source_sel && match) |=> bus_power_reset_req)
        else $error("reset request missing");

    chk_reset_req_off: assert property (@(posedge mclk) disable iff (!resetn)
        !reset_source_sel |=> !bus_power_reset_req)
        else $error("spurious reset request");

    chk_reset_req_drop: assert property (@(posedge mclk) disable iff (!resetn)
        !match |=> !bus_power_reset_req)
        else $error("reset request latched");

    // Writes of one reach the off output.
    chk_off_write: assert property (@(posedge mclk) disable iff (!resetn)
        s_write_off(1'b1) |=> regulator_off)
        else $error("off not set");

    // Writes of zero clear the off output.
    chk_off_clear: assert property (@(posedge mclk) disable iff (!resetn)
        s_write_off(1'b0) |=> !regulator_off)
        else $error("off not cleared");

    // Control bits hold without a write.
    chk_ctrl_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !(sfr_wr && hit) |=> $stable(regulator_off) && $stable(regulator_low_power_select))
        else $error("control bit changed");

    chk_low_power_write: assert property (@(posedge mclk) disable iff (!resetn)
        s_write_hit |=> regulator_low_power_select == $past(sfr_wdata[`BIT_LOW_POWER]))
        else $error("low power bit wrong");

    chk_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
        (sfr_rdata & `RESERVED_MASK) == 8'h00)
        else $error("reserved nonzero");

    // Read data zero when not reading.
    chk_rdata_idle: assert property (@(posedge mclk) disable iff (!resetn)
        !(sfr_rd && hit) |=> sfr_rdata == 8'h00)
        else $error("read data not cleared");

    chk_status_read: assert property (@(posedge mclk) disable iff (!resetn)
        s_read_hit |=> sfr_rdata[`BIT_BUS_PRESENT] == $past(bus_power_present))
        else $error("status wrong");

    chk_readback_fields: assert property (@(posedge mclk) disable iff (!resetn)
        s_read_hit |=> sfr_rdata[`BIT_IRQ_POL] == $past(bus_power_irq_polarity) &&
            sfr_rdata[`BIT_REG_OFF] == $past(regulator_off))
        else $error("readback wrong");

    chk_polarity_write: assert property (@(posedge mclk) disable iff (!resetn)
        s_write_hit |=> bus_power_irq_polarity == $past(sfr_wdata[`BIT_IRQ_POL]))
        else $error("polarity wrong");

    // Synchronised level lags the pin by two edges.
    chk_sync_delay: assert property (@(posedge mclk) disable iff (!resetn)
        ($past(resetn) && $past(resetn, 2)) |-> bus_power_present == $past(vbus_pin, 2))
        else $error("sync delay wrong");
endmodule : regulator_vbus_control

// ==== test/vbus_source.sv ====
/*
 Model of the host supply line on the detect pin.
 Assumes the bench requests levels; the pin follows after an unclocked delay.
*/
`timescale 1ns/1ps
module vbus_source (
    input wire logic level_req,
    output logic vbus_pin
);
    initial begin
        vbus_pin = 1'b0;
        forever begin
            @(level_req);
            vbus_pin <= #3 level_req;
        end
    end
endmodule : vbus_source

// ==== test/testbench.sv ====
/*
 Self-checking bench for the regulator control register.
 Assumes the design files and the supply-line model are compiled first.
*/
`timescale 1ns/1ps
`include "regulator_vbus_defs.svh"
module testbench;
    import regulator_vbus_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic irq_enable = 1'b0;
    logic reset_source_sel = 1'b0;
    logic level_req = 1'b0;
    sfr_addr_t sfr_addr = 8'h00;
    sfr_addr_t a;
    sfr_byte_t sfr_wdata = 8'h00;
    sfr_byte_t sfr_rdata, rd_val, d;
    sfr_byte_t shadow = 8'h00;
    logic vbus_pin, regulator_off, regulator_low_power_select;
    logic bus_power_irq, bus_power_reset_req, m, prev_lvl;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'h2feb9e5a;
    always #5 mclk = ~mclk;
    vbus_source far (.level_req(level_req), .vbus_pin(vbus_pin));
    regulator_vbus_control dut (.mclk(mclk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .vbus_pin(vbus_pin), .irq_enable(irq_enable), .reset_source_sel(reset_source_sel),
        .regulator_off(regulator_off), .regulator_low_power_select(regulator_low_power_select),
        .bus_power_irq(bus_power_irq), .bus_power_reset_req(bus_power_reset_req));
    function automatic sfr_byte_t exp_rd(sfr_byte_t s, logic p);
        return {s[7], p, s[5:4], 4'h0};
    endfunction : exp_rd
    task automatic check(string what, sfr_byte_t exp, sfr_byte_t got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic acc(sfr_addr_t ad, logic w, logic r, sfr_byte_t wd);
        sfr_addr = ad;
        sfr_wr = w;
        sfr_rd = r;
        sfr_wdata = wd;
        @(posedge mclk);
        #1;
        rd_val = sfr_rdata;
    endtask : acc
    task automatic idle();
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        @(posedge mclk);
        #1;
    endtask : idle
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        #1 resetn = 1'b1;
        acc(`REG_CTRL_ADDR, 1'b0, 1'b1, 8'h00);
        check("reset value", 8'h00, rd_val);
        for (int i = 0; i < 24; i++) begin
            d = 8'($random(seed)) & 8'hf0;
            a = (i % 6 == 5) ? 8'hc8 : `REG_CTRL_ADDR;
            acc(a, 1'b1, 1'b0, d);
            if (a == `REG_CTRL_ADDR) shadow = d & 8'hb0;
            check("control outputs", {6'h00, shadow[7], shadow[4]},
                {6'h00, regulator_off, regulator_low_power_select});
            acc(a, 1'b0, 1'b1, 8'h00);
            check("read back", (a == `REG_CTRL_ADDR) ? exp_rd(shadow, 1'b0) : 8'h00,
                rd_val);
        end
        acc(`REG_CTRL_ADDR, 1'b1, 1'b1, 8'h90);
        check("read during write", exp_rd(shadow, 1'b0), rd_val);
        shadow = 8'h90;
        for (int k = 0; k < 32; k++) begin
            shadow[5] = k[0];
            acc(`REG_CTRL_ADDR, 1'b1, 1'b0, shadow);
            idle();
            prev_lvl = level_req;
            level_req = k[1];
            irq_enable = k[2] | k[4];
            reset_source_sel = k[3];
            repeat (2) @(posedge mclk);
            #1;
            check("irq lag", {7'h00, irq_enable & (prev_lvl == k[0])}, {7'h00, bus_power_irq});
            repeat (2) @(posedge mclk);
            #1;
            m = (k[1] == k[0]);
            check("irq", {7'h00, irq_enable & m}, {7'h00, bus_power_irq});
            check("reset req", {7'h00, reset_source_sel & m}, {7'h00, bus_power_reset_req});
            acc(`REG_CTRL_ADDR, 1'b0, 1'b1, 8'h00);
            check("status", exp_rd(shadow, k[1]), rd_val);
            idle();
        end
        resetn = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        check("outputs in reset", 8'h00, {4'h0, regulator_off, regulator_low_power_select,
            bus_power_irq, bus_power_reset_req});
        resetn = 1'b1;
        acc(`REG_CTRL_ADDR, 1'b0, 1'b1, 8'h00);
        check("reset value again", 8'h00, rd_val);
        idle();
        report_and_stop();
    end
endmodule : testbench
